// *** core/wolc_pkg.sv ***
// Constants and register layout of the wake-on-LAN controller
package wolc_pkg;
  localparam int DW = 32;
  localparam int BYTE_W = 8;
  localparam int LANES = 4;
  // Register byte addresses
  localparam logic [7:0] OFS_RECEIVE_DESCRIPTOR_POINTER = 8'h30;
  localparam logic [7:0] OFS_PWR = 8'h3C;
  localparam logic [7:0] OFS_WAKE_COMMAND_STATUS = 8'h40;
  localparam logic [7:0] OFS_PCNT = 8'h50;
  // Wake command/status flags
  localparam int B_SPEC = 31;
  localparam int B_PAT = 27;
  localparam int B_ARP = 26;
  localparam int B_BCAST = 25;
  localparam int B_MCAST = 24;
  localparam int B_UCAST = 23;
  localparam int B_PHY = 22;
  localparam int B_INTR = 20;
  // Wake command/status enables
  localparam int E_PWCHK = 10;
  localparam int E_SPEC = 9;
  localparam int E_PAT = 5;
  localparam int E_ARP = 4;
  localparam int E_BCAST = 3;
  localparam int E_MCAST = 2;
  localparam int E_UCAST = 1;
  localparam int E_PHY = 0;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  localparam logic [31:0] WAKE_COMMAND_STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] WAKE_COMMAND_STATUS_FLAGS = 32'hFFF0_0000;
  localparam logic [31:0] WAKE_COMMAND_STATUS_WAKE = 32'hFFC0_0000;
  localparam logic [31:0] WAKE_COMMAND_STATUS_CTRL = 32'h0000_07FF;
  localparam logic [31:0] WAKE_COMMAND_STATUS_USED = 32'hFFD0_07FF;
  // Power control fields
  localparam int P_PIN = 16;
  localparam int P_STAT = 15;
  localparam int P_EN = 8;
  localparam int P_IRQ = 1;
  // Pattern buffers
  localparam int PAT_NUM = 4;
  localparam int PAT_SEL_W = 2;
  localparam int PAT_AW = 7;
  localparam int PAT_CW = 8;
  localparam int PAT_WW = 9;
  localparam int PAT_MASK = 8;
  localparam int PAT_MIN = 2;
  localparam int PAT_SHORT = 64;
  localparam int PAT_LONG = 128;
  localparam int PAT_NSHORT = 2;
  // Request pin pulse
  localparam int CLK_PS = 8000;
  localparam int PS_PER_NS = 1000;
  localparam int PME_NS = 64;
  localparam int PME_CYC = (PME_NS * PS_PER_NS + CLK_PS - 1) / CLK_PS;
  localparam int PME_W = 8;
endpackage

// *** core/wolc_pat_if.sv ***
// Pattern memory port between a matcher and its store
`timescale 1ns/1ps
`default_nettype none
interface wolc_pat_if #(parameter int AW = 7, parameter int WW = 9) ();
  logic ce;
  logic [AW-1:0] rd_addr;
  logic [WW-1:0] rd_data;
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [WW-1:0] wr_data;
  modport store (input ce, input rd_addr, input wr_en, input wr_addr,
    input wr_data, output rd_data);
  modport match (input ce, input rd_data, output rd_addr);
endinterface
`default_nettype wire

// *** core/wolc_pat_mem.sv ***
// Pattern byte store with registered read
`timescale 1ns/1ps
`default_nettype none
module wolc_pat_mem import wolc_pkg::*; #(
  parameter int AW = PAT_AW,
  parameter int WW = PAT_WW
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  wolc_pat_if.store mem
);
  localparam int DEPTH = 2 ** AW;
  typedef struct packed {
    logic [DEPTH-1:0][WW-1:0] words;
    logic [WW-1:0] rdata;
  } wolc_mem_t;
  wolc_mem_t s;
  wolc_mem_t next_s;

  // Read sees the old word when write and read hit one address
  always_comb begin
    next_s = s;
    if (mem.wr_en) begin
      next_s.words[mem.wr_addr] = mem.wr_data;
    end
    next_s.rdata = s.words[mem.rd_addr];
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else if (mem.ce) begin
      s <= next_s;
    end
  end

  assign mem.rd_data = s.rdata;
endmodule // wolc_pat_mem
`default_nettype wire

// *** core/wolc_pat_match.sv ***
// Byte-serial pattern matcher for one pattern buffer
`timescale 1ns/1ps
`default_nettype none
module wolc_pat_match import wolc_pkg::*; #(
  parameter int AW = PAT_AW,
  parameter int CW = PAT_CW,
  parameter int MAX_LEN = PAT_SHORT
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Receive bytes
  input wire logic byte_valid_in,
  input wire logic [BYTE_W-1:0] byte_in,
  input wire logic byte_last_in,
  // Pattern length and memory
  input wire logic [CW-1:0] count_in,
  wolc_pat_if.match mem,
  // Result, held until the next packet starts
  output logic hit_out
);
  typedef struct packed {
    logic [AW-1:0] idx;
    logic alive;
    logic first;
    logic hit;
  } wolc_match_t;
  localparam wolc_match_t RST = '{idx: '0, alive: 1'b1, first: 1'b1,
    hit: 1'b0};
  localparam logic [CW-1:0] MIN_CNT = CW'(PAT_MIN);
  localparam logic [CW-1:0] MAX_CNT = CW'(MAX_LEN);
  localparam logic [CW-1:0] ONE = CW'(1);
  wolc_match_t s;
  wolc_match_t next_s;
  logic count_ok;
  logic byte_ok;
  logic [CW-1:0] pos;

  always_comb begin
    next_s = s;
    count_ok = (count_in >= MIN_CNT) && (count_in <= MAX_CNT); // R17
    pos = CW'(s.idx) + ONE;
    byte_ok = mem.rd_data[PAT_MASK] ||
      (mem.rd_data[BYTE_W-1:0] == byte_in); // R18
    if (byte_valid_in) begin
      if (s.first) begin
        next_s.hit = 1'b0;
        next_s.first = 1'b0;
      end
      if (s.alive && count_ok) begin
        if (!byte_ok) begin
          next_s.alive = 1'b0;
        end else if (pos == count_in) begin
          next_s.hit = 1'b1;
          next_s.alive = 1'b0;
        end else begin
          next_s.idx = AW'(s.idx + 1'b1); // R18
        end
      end
      if (byte_last_in) begin
        next_s.idx = '0;
        next_s.alive = 1'b1;
        next_s.first = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= RST;
    end else if (mem.ce) begin
      s <= next_s;
    end
  end

  // Address the next byte so its word is ready when that byte arrives
  assign mem.rd_addr = next_s.idx;
  assign hit_out = s.hit;
endmodule // wolc_pat_match
`default_nettype wire

// *** core/wolc_wake_ctrl.sv ***
// Wake-on-LAN command and status logic
// Contract
// (R1) Special wake frame with its enable set latches bit 31, cleared on read.
// (R2) Pattern 3..0 hits with enables 8..5 latch bits 30..27, read-cleared.
// (R3) ARP packet with bit 4 enabled latches bit 26, read-cleared.
// (R4) Broadcast packet with bit 3 enabled latches bit 25, read-cleared.
// (R5) Multicast packet with bit 2 enabled latches bit 24, read-cleared.
// (R6) Unicast packet with bit 1 enabled latches bit 23, read-cleared.
// (R7) PHY event with bit 0 enabled latches bit 22, read-cleared.
// (R8) Wrong password on special frame, both enables set, latches bit 20.
// (R9) Password check in bit 10 acts only while bit 9 is set.
// (R10) Any enabled wake condition raises wake event and pulses request pin.
// (R11) A wake can also raise a wake interrupt to software.
// (R12) Wake packet stays held in receive FIFO until descriptor given.
// (R13) Software writes a null descriptor pointer before entering low power.
// (R14) Software wakes device and restores config space after D3hot.
// (R15) Software then writes a valid descriptor pointer to release packet.
// (R16) Enabled pattern raises wake for packet matching its own buffer.
// (R17) Pattern length 2 to 64 bytes, or 128 for patterns 2 and 3.
// (R18) Patterns compare byte by byte; masked bytes are don't-care.
// (R19) Request pin may be driven only while power request enable is set.
// (R20) Bits 19 to 11 read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module wolc_wake_ctrl import wolc_pkg::*; #(
  parameter int PME_PULSE = PME_CYC
) (
  // Clock, reset, enable
  input wire logic REF_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic CLK_EN_IN,
  input wire logic SOFT_RESET_IN,
  // Wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [LANES-1:0] WB_SEL_IN,
  input wire logic [DW-1:0] WB_DAT_IN,
  output logic [DW-1:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // Receive filter classification
  input wire logic PKT_DONE_IN,
  input wire logic PKT_SPECIAL_IN,
  input wire logic PKT_PASSWORD_OK_IN,
  input wire logic PKT_ARP_IN,
  input wire logic PKT_BROADCAST_IN,
  input wire logic PKT_MULTICAST_IN,
  input wire logic PKT_UNICAST_IN,
  input wire logic PHY_EVENT_IN,
  // Receive byte stream
  input wire logic RX_BYTE_VALID_IN,
  input wire logic [BYTE_W-1:0] RX_BYTE_IN,
  input wire logic RX_BYTE_LAST_IN,
  // Pattern memory load
  input wire logic PAT_WR_EN_IN,
  input wire logic [PAT_SEL_W-1:0] PAT_WR_SEL_IN,
  input wire logic [PAT_AW-1:0] PAT_WR_ADDR_IN,
  input wire logic [PAT_WW-1:0] PAT_WR_DATA_IN,
  // Power management
  input wire logic POWER_REQUEST_PIN_IN,
  output logic POWER_REQUEST_PIN_OUT,
  output logic POWER_REQUEST_PIN_OE_OUT,
  output logic WAKE_EVENT_OUT,
  output logic WAKE_IRQ_OUT,
  output logic RX_HOLD_OUT,
  output logic [DW-1:0] RECEIVE_DESCRIPTOR_POINTER_OUT
);
  typedef struct packed {
    logic [DW-1:0] wake_command_status;
    logic [DW-1:0] receive_descriptor_pointer;
    logic [DW-1:0] pcnt;
    logic pme_en;
    logic pme_stat;
    logic irq_en;
    logic [PME_W-1:0] pulse;
    logic pin_drive;
    logic wake_evt;
    logic wake_irq;
    logic rx_hold;
    logic ack;
    logic [DW-1:0] rdata;
    logic pin_meta;
    logic pin_sync;
  } wolc_state_t;

  localparam logic [PME_W-1:0] PULSE_LEN = PME_W'(PME_PULSE);
  localparam logic [PME_W-1:0] PULSE_ONE = PME_W'(1);

  wolc_state_t s;
  wolc_state_t next_s;
  logic [PAT_NUM-1:0] pat_hit;
  logic take;
  logic wr;
  logic rd;
  logic [DW-1:0] bmask;
  logic [DW-1:0] set_vec;
  logic [DW-1:0] pwr_view;
  logic [DW-1:0] new_receive_descriptor_pointer;
  logic special_ok;
  logic wake;

  function automatic logic [DW-1:0] lane_mask(
    input logic [LANES-1:0] sel);
    logic [DW-1:0] m;
    m = ZERO;
    for (int b = 0; b < LANES; b++) begin
      m[b*BYTE_W +: BYTE_W] = {BYTE_W{sel[b]}};
    end
    return m;
  endfunction

  // Pattern buffers, each with its own store and matcher
  for (genvar g = 0; g < PAT_NUM; g++) begin : g_pat
    wolc_pat_if #(.AW(PAT_AW), .WW(PAT_WW)) port ();
    assign port.ce = CLK_EN_IN;
    assign port.wr_en = PAT_WR_EN_IN &&
      (PAT_WR_SEL_IN == PAT_SEL_W'(g));
    assign port.wr_addr = PAT_WR_ADDR_IN;
    assign port.wr_data = PAT_WR_DATA_IN;
    wolc_pat_mem #(.AW(PAT_AW), .WW(PAT_WW)) u_mem (
      .clk_in(REF_CLK_IN),
      .rst_n_in(RESETN_IN),
      .mem(port)
    );
    wolc_pat_match #(
      .AW(PAT_AW),
      .CW(PAT_CW),
      .MAX_LEN(g < PAT_NSHORT ? PAT_SHORT : PAT_LONG) // R17
    ) u_match (
      .clk_in(REF_CLK_IN),
      .rst_n_in(RESETN_IN),
      .byte_valid_in(RX_BYTE_VALID_IN),
      .byte_in(RX_BYTE_IN),
      .byte_last_in(RX_BYTE_LAST_IN),
      .count_in(s.pcnt[g*PAT_CW +: PAT_CW]),
      .mem(port),
      .hit_out(pat_hit[g])
    );
  end

  always_comb begin
    next_s = s;
    take = WB_CYC_IN && WB_STB_IN && !s.ack;
    wr = take && WB_WE_IN;
    rd = take && !WB_WE_IN;
    bmask = lane_mask(WB_SEL_IN);
    new_receive_descriptor_pointer = (s.receive_descriptor_pointer & ~bmask) | (WB_DAT_IN & bmask);
    pwr_view = ZERO;
    pwr_view[P_PIN] = s.pin_sync;
    pwr_view[P_STAT] = s.pme_stat;
    pwr_view[P_EN] = s.pme_en;
    pwr_view[P_IRQ] = s.irq_en;
    // Wrong password blocks the wake only while the password check enable is set
    special_ok = PKT_SPECIAL_IN && s.wake_command_status[E_SPEC] &&
      (!s.wake_command_status[E_PWCHK] || PKT_PASSWORD_OK_IN); // R9
    set_vec = ZERO;
    if (PKT_DONE_IN) begin
      set_vec[B_SPEC] = special_ok; // R1
      for (int i = 0; i < PAT_NUM; i++) begin
        set_vec[B_PAT+i] = pat_hit[i] && s.wake_command_status[E_PAT+i]; // R2 R16
      end
      set_vec[B_ARP] = PKT_ARP_IN && s.wake_command_status[E_ARP]; // R3
      set_vec[B_BCAST] = PKT_BROADCAST_IN && s.wake_command_status[E_BCAST]; // R4
      set_vec[B_MCAST] = PKT_MULTICAST_IN && s.wake_command_status[E_MCAST]; // R5
      set_vec[B_UCAST] = PKT_UNICAST_IN && s.wake_command_status[E_UCAST]; // R6
      set_vec[B_INTR] = PKT_SPECIAL_IN && s.wake_command_status[E_SPEC] &&
        s.wake_command_status[E_PWCHK] && !PKT_PASSWORD_OK_IN; // R8
    end
    set_vec[B_PHY] = PHY_EVENT_IN && s.wake_command_status[E_PHY]; // R7
    wake = |(set_vec & WAKE_COMMAND_STATUS_WAKE); // R10
    // Bus answer, one cycle after the request
    next_s.ack = take;
    if (take) begin
      case (WB_ADR_IN)
        OFS_WAKE_COMMAND_STATUS: next_s.rdata = s.wake_command_status & WAKE_COMMAND_STATUS_USED; // R20
        OFS_RECEIVE_DESCRIPTOR_POINTER: next_s.rdata = s.receive_descriptor_pointer;
        OFS_PWR: next_s.rdata = pwr_view;
        OFS_PCNT: next_s.rdata = s.pcnt;
        default: next_s.rdata = ZERO;
      endcase
    end
    if (wr) begin
      case (WB_ADR_IN)
        OFS_WAKE_COMMAND_STATUS: begin
          next_s.wake_command_status = (s.wake_command_status & ~(WAKE_COMMAND_STATUS_CTRL & bmask)) |
            (WB_DAT_IN & WAKE_COMMAND_STATUS_CTRL & bmask); // R20
        end
        OFS_RECEIVE_DESCRIPTOR_POINTER: begin
          next_s.receive_descriptor_pointer = new_receive_descriptor_pointer;
          if (new_receive_descriptor_pointer != ZERO) begin
            next_s.rx_hold = 1'b0; // R12
          end
        end
        OFS_PWR: begin
          if (bmask[P_EN]) begin
            next_s.pme_en = WB_DAT_IN[P_EN];
          end
          if (bmask[P_IRQ]) begin
            next_s.irq_en = WB_DAT_IN[P_IRQ];
          end
          if (bmask[P_STAT] && WB_DAT_IN[P_STAT]) begin
            next_s.pme_stat = 1'b0;
          end
        end
        OFS_PCNT: next_s.pcnt = (s.pcnt & ~bmask) | (WB_DAT_IN & bmask);
        default: ;
      endcase
    end
    // Flags clear on read; a flag set in that cycle survives
    if (rd && WB_ADR_IN == OFS_WAKE_COMMAND_STATUS) begin
      next_s.wake_command_status = next_s.wake_command_status & ~WAKE_COMMAND_STATUS_FLAGS; // R1 R2 R3 R4 R5 R6 R7 R8
    end
    if (SOFT_RESET_IN) begin
      next_s.wake_command_status = WAKE_COMMAND_STATUS_RST;
    end
    next_s.wake_command_status = next_s.wake_command_status | set_vec;
    next_s.wake_evt = wake; // R10
    next_s.wake_irq = wake && s.irq_en; // R11
    if (wake) begin
      next_s.pme_stat = 1'b1;
      next_s.rx_hold = 1'b1; // R12
    end
    // Pulse restarts on each wake; clearing enable ends it at once
    if (wake && s.pme_en) begin
      next_s.pulse = PULSE_LEN; // R10
    end else if (s.pulse != '0) begin
      next_s.pulse = s.pulse - PULSE_ONE;
    end
    if (!next_s.pme_en) begin
      next_s.pulse = '0; // R19
    end
    next_s.pin_drive = next_s.pulse != '0;
    next_s.pin_meta = POWER_REQUEST_PIN_IN;
    next_s.pin_sync = s.pin_meta;
  end

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      s <= '0;
    end else if (CLK_EN_IN) begin
      s <= next_s;
    end
  end

  assign WB_DAT_OUT = s.rdata;
  assign WB_ACK_OUT = s.ack;
  // Open drain: only ever pulls low
  assign POWER_REQUEST_PIN_OUT = 1'b0;
  assign POWER_REQUEST_PIN_OE_OUT = s.pin_drive; // R19
  assign WAKE_EVENT_OUT = s.wake_evt;
  assign WAKE_IRQ_OUT = s.wake_irq;
  assign RX_HOLD_OUT = s.rx_hold;
  assign RECEIVE_DESCRIPTOR_POINTER_OUT = s.receive_descriptor_pointer;

  // Checks
  logic rd_wake_command_status;
  logic pwr_wr;
  logic [PME_W-1:0] drive_len;
  assign rd_wake_command_status = rd && WB_ADR_IN == OFS_WAKE_COMMAND_STATUS;
  assign pwr_wr = wr && WB_ADR_IN == OFS_PWR;

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      drive_len <= '0;
    end else if (CLK_EN_IN) begin
      // A new wake restarts the pulse, so the width count starts over
      drive_len <= (s.pin_drive && !(wake && s.pme_en)) ?
        PME_W'(drive_len + PULSE_ONE) : '0;
    end
  end

  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);

  AST_BUS_ACK:
    assert property (CLK_EN_IN && take |=> WB_ACK_OUT ##1
      (!WB_ACK_OUT || !$past(CLK_EN_IN)))
    else $error("bus request not answered in one cycle");
  AST_SPECIAL_SET: // R1
    assert property (CLK_EN_IN && PKT_DONE_IN && PKT_SPECIAL_IN &&
      s.wake_command_status[E_SPEC] && (!s.wake_command_status[E_PWCHK] || PKT_PASSWORD_OK_IN)
      |=> s.wake_command_status[B_SPEC] && WAKE_EVENT_OUT)
    else $error("special frame flag not set");
  AST_PATTERN_SET: // R2
    assert property (CLK_EN_IN && PKT_DONE_IN && pat_hit[PAT_NUM-1] &&
      s.wake_command_status[E_PAT+PAT_NUM-1] |=> s.wake_command_status[B_PAT+PAT_NUM-1])
    else $error("pattern flag not set");
  AST_ARP_SET: // R3
    assert property (CLK_EN_IN && PKT_DONE_IN && PKT_ARP_IN &&
      s.wake_command_status[E_ARP] |=> s.wake_command_status[B_ARP])
    else $error("ARP flag not set");
  AST_BCAST_GATED: // R4
    assert property (CLK_EN_IN && !s.wake_command_status[E_BCAST] && !s.wake_command_status[B_BCAST]
      |=> !s.wake_command_status[B_BCAST])
    else $error("broadcast flag set while disabled");
  AST_MCAST_SET: // R5
    assert property (CLK_EN_IN && PKT_DONE_IN && PKT_MULTICAST_IN &&
      s.wake_command_status[E_MCAST] |=> s.wake_command_status[B_MCAST])
    else $error("multicast flag not set");
  AST_READ_CLEARS: // R6
    assert property (CLK_EN_IN && rd_wake_command_status && !PKT_DONE_IN &&
      !PHY_EVENT_IN |=> (s.wake_command_status & WAKE_COMMAND_STATUS_FLAGS) == ZERO)
    else $error("flags survive a read");
  AST_PHY_SET: // R7
    assert property (CLK_EN_IN && PHY_EVENT_IN && s.wake_command_status[E_PHY]
      |=> s.wake_command_status[B_PHY] && WAKE_EVENT_OUT)
    else $error("PHY flag not set");
  AST_INTRUSION: // R8
    assert property (CLK_EN_IN && PKT_DONE_IN && PKT_SPECIAL_IN &&
      !PKT_PASSWORD_OK_IN && s.wake_command_status[E_SPEC] && s.wake_command_status[E_PWCHK] &&
      !s.wake_command_status[B_SPEC] && !SOFT_RESET_IN
      |=> s.wake_command_status[B_INTR] && !s.wake_command_status[B_SPEC])
    else $error("intrusion not flagged or wrongly woke");
  AST_PWCHK_IDLE: // R9
    assert property (CLK_EN_IN && !s.wake_command_status[E_SPEC] && !s.wake_command_status[B_INTR]
      |=> !s.wake_command_status[B_INTR])
    else $error("password check acted without special enable");
  AST_PIN_PULSE: // R10
    assert property (CLK_EN_IN && wake && s.pme_en && !pwr_wr
      |=> POWER_REQUEST_PIN_OE_OUT && WAKE_EVENT_OUT)
    else $error("wake did not drive request pin");
  AST_PIN_WIDTH: // R10
    assert property (drive_len <= PULSE_LEN)
    else $error("request pin held too long");
  AST_WAKE_IRQ: // R11
    assert property (CLK_EN_IN && wake && s.irq_en |=> WAKE_IRQ_OUT)
    else $error("wake interrupt missing");
  AST_RX_HOLD: // R12
    assert property (CLK_EN_IN && wake |=> RX_HOLD_OUT [*1] ##0
      (RECEIVE_DESCRIPTOR_POINTER_OUT == $past(s.receive_descriptor_pointer) ||
      $past(wr)))
    else $error("wake packet not held");
  AST_PIN_GATED: // R19
    assert property (POWER_REQUEST_PIN_OE_OUT |-> s.pme_en)
    else $error("request pin driven while disabled");
  AST_UNUSED_ZERO: // R20
    assert property ((s.wake_command_status & ~WAKE_COMMAND_STATUS_USED) == ZERO)
    else $error("unused bits not zero");

  COV_SPECIAL_WAKE:
    cover property (CLK_EN_IN && PKT_DONE_IN && special_ok);
  COV_PATTERN_WAKE:
    cover property (CLK_EN_IN && PKT_DONE_IN && |pat_hit ##1
      WAKE_EVENT_OUT);
  COV_INTRUSION:
    cover property (CLK_EN_IN && set_vec[B_INTR]);
  COV_READ_CLEAR:
    cover property (CLK_EN_IN && rd_wake_command_status && s.wake_command_status[B_PHY]);
endmodule // wolc_wake_ctrl
`default_nettype wire

// *** sim/wolc_host_model.sv ***
// Host side of the open-drain power request line
`timescale 1ns/1ps
`default_nettype none
module wolc_host_model (
  input wire logic clk_in,
  input wire logic drive_in,
  input wire logic oe_in,
  output logic pin_out,
  output int pulses_out
);
  logic oe_q = 1'b0;
  // Pull-up holds the line high whenever nobody pulls it low
  assign pin_out = oe_in ? drive_in : 1'b1;
  // Host counts each request pulse as one power-state change request
  always @(posedge clk_in) begin
    oe_q <= oe_in;
    if (oe_in && !oe_q) pulses_out <= pulses_out + 1;
  end
endmodule // wolc_host_model
`default_nettype wire

// *** sim/tb_wake_on_lan_control.sv ***
// Self-checking bench for the wake-on-LAN controller
`timescale 1ns/1ps
`default_nettype none
module tb_wake_on_lan_control;
  import wolc_pkg::*;
  localparam int PM = 2;
  logic clk, rst_n, soft_rst, cyc, stb, we, ack, irq_en, pme_en, ce;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, ptr, q, r;
  logic done, spec, pwok, arp, bc, mc, uc, phy, bval, blast, pwen;
  logic [7:0] bdat;
  logic [1:0] psel;
  logic [6:0] padr;
  logic [8:0] pdat;
  logic pin, pin_oe, pin_drv, wake, irq, hold;
  int err_total, total_checks, cycles, seed, cur, last_w, pulses;

  wolc_wake_ctrl #(.PME_PULSE(PM)) u_wolc_wake_ctrl (
    .REF_CLK_IN(clk), .RESETN_IN(rst_n), .CLK_EN_IN(ce),
    .SOFT_RESET_IN(soft_rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .PKT_DONE_IN(done),
    .PKT_SPECIAL_IN(spec), .PKT_PASSWORD_OK_IN(pwok), .PKT_ARP_IN(arp),
    .PKT_BROADCAST_IN(bc), .PKT_MULTICAST_IN(mc), .PKT_UNICAST_IN(uc),
    .PHY_EVENT_IN(phy), .RX_BYTE_VALID_IN(bval), .RX_BYTE_IN(bdat),
    .RX_BYTE_LAST_IN(blast), .PAT_WR_EN_IN(pwen), .PAT_WR_SEL_IN(psel),
    .PAT_WR_ADDR_IN(padr), .PAT_WR_DATA_IN(pdat),
    .POWER_REQUEST_PIN_IN(pin), .POWER_REQUEST_PIN_OUT(pin_drv),
    .POWER_REQUEST_PIN_OE_OUT(pin_oe), .WAKE_EVENT_OUT(wake),
    .WAKE_IRQ_OUT(irq), .RX_HOLD_OUT(hold),
    .RECEIVE_DESCRIPTOR_POINTER_OUT(ptr));

  wolc_host_model u_wolc_host_model (.clk_in(clk), .drive_in(pin_drv),
    .oe_in(pin_oe), .pin_out(pin), .pulses_out(pulses));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Width of the last request pulse, seen from the wire
  always @(posedge clk) begin
    cycles++;
    if (pin === 1'b0) cur++;
    else begin
      if (cur != 0) last_w = cur;
      cur = 0;
    end
    if (cycles == 6000) begin
      err_total++;
      $display("CHECK FAILED at %0t: timeout", $time);
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    chk(32'(n), 32'd2, "bus ack delay");
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic pw(input logic [1:0] s, input logic [6:0] a,
      input logic [8:0] d);
    @(posedge clk);
    pwen <= 1'b1;
    psel <= s;
    padr <= a;
    pdat <= d;
    @(posedge clk);
    pwen <= 1'b0;
  endtask

  // Two-byte packet, then its classification one cycle after the last byte
  task automatic pkt(input logic [6:0] c, input logic [7:0] b0, b1);
    @(posedge clk);
    bval <= 1'b1;
    bdat <= b0;
    @(posedge clk);
    bdat <= b1;
    blast <= 1'b1;
    @(posedge clk);
    bval <= 1'b0;
    blast <= 1'b0;
    done <= 1'b1;
    {spec, pwok, arp, bc, mc, uc, phy} <= c;
    @(posedge clk);
    done <= 1'b0;
    {spec, pwok, arp, bc, mc, uc, phy} <= 7'h00;
    #1;
  endtask

  // Pattern 0 is A5 then a masked byte, pattern 3 is 3C C3, 1 and 2 unset
  function automatic logic [31:0] flags(input logic [10:0] en,
      input logic [6:0] c, input logic [7:0] b0, b1);
    logic [31:0] f;
    f = ZERO;
    if (c[6] && en[E_SPEC]) begin
      if (en[E_PWCHK] && !c[5]) f[B_INTR] = 1'b1;
      else f[B_SPEC] = 1'b1;
    end
    f[B_PAT+3] = en[E_PAT+3] && b0 == 8'h3C && b1 == 8'hC3;
    f[B_PAT] = en[E_PAT] && b0 == 8'hA5;
    f[B_PHY +: 5] = c[4:0] & en[4:0];
    return f;
  endfunction

  task automatic run(input logic [10:0] en, input logic [6:0] c,
      input logic [7:0] b0, b1);
    logic [31:0] f;
    logic w;
    f = flags(en, c, b0, b1);
    w = |(f & WAKE_COMMAND_STATUS_WAKE);
    wb(1'b1, OFS_WAKE_COMMAND_STATUS, {21'h0, en}, q);
    pkt(c, b0, b1);
    chk(32'(wake), 32'(w), "wake event");
    chk(32'(irq), 32'(w & irq_en), "wake irq");
    chk(32'(pin_oe), 32'(w & pme_en), "request pin");
    wb(1'b0, OFS_WAKE_COMMAND_STATUS, ZERO, q);
    chk(q, f | {21'h0, en}, "flags");
    wb(1'b0, OFS_WAKE_COMMAND_STATUS, ZERO, q);
    chk(q, {21'h0, en}, "clear on read");
  endtask

  initial begin
    seed = 32'h7638;
    ce = 1'b1;
    {rst_n, soft_rst, cyc, stb, we, done, bval, blast, pwen} = '0;
    {spec, pwok, arp, bc, mc, uc, phy} = '0;
    {adr, wdat, bdat, psel, padr, pdat} = '0;
    {err_total, total_checks, cycles, cur, last_w} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, OFS_WAKE_COMMAND_STATUS, ZERO, q);
    chk(q, WAKE_COMMAND_STATUS_RST, "reset value");
    wb(1'b1, OFS_WAKE_COMMAND_STATUS, 32'hFFFF_FFFF, q);
    wb(1'b0, OFS_WAKE_COMMAND_STATUS, ZERO, q);
    chk(q, WAKE_COMMAND_STATUS_CTRL, "unused and status bits");
    wb(1'b1, 8'h7C, 32'hFFFF_FFFF, q);
    wb(1'b0, 8'h7C, ZERO, q);
    chk(q, ZERO, "unmapped read");
    @(posedge clk);
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    wb(1'b0, OFS_WAKE_COMMAND_STATUS, ZERO, q);
    chk(q, ZERO, "soft reset");
    wb(1'b1, OFS_RECEIVE_DESCRIPTOR_POINTER, ZERO, q);
    pw(2'd0, 7'd0, 9'h0A5);
    pw(2'd0, 7'd1, 9'h100);
    pw(2'd3, 7'd0, 9'h03C);
    pw(2'd3, 7'd1, 9'h0C3);
    wb(1'b1, OFS_PCNT, 32'h0200_0002, q);
    irq_en = 1'b1;
    pme_en = 1'b1;
    wb(1'b1, OFS_PWR, 32'h0000_0102, q);
    for (int k = 0; k < 5; k++) run(11'h1 << k, 7'h1 << k, 8'h00, 8'h00);
    chk(32'(last_w), PM, "request pulse width");
    chk(32'(pulses), 5, "host saw requests");
    chk(32'(hold), 1, "wake packet held");
    wb(1'b0, OFS_PWR, ZERO, q);
    chk(q, 32'h0001_8102, "power status after wake");
    wb(1'b1, OFS_PWR, 32'h0000_8102, q);
    wb(1'b0, OFS_PWR, ZERO, q);
    chk(q, 32'h0001_0102, "power status cleared");
    run(11'h000, 7'h7F, 8'h3C, 8'hC3);
    run(11'h600, 7'h40, 8'h00, 8'h00);
    run(11'h600, 7'h60, 8'h00, 8'h00);
    run(11'h400, 7'h40, 8'h00, 8'h00);
    run(11'h200, 7'h40, 8'h00, 8'h00);
    run(11'h020, 7'h00, 8'hA5, 8'h77);
    run(11'h100, 7'h00, 8'h3C, 8'hC3);
    run(11'h100, 7'h00, 8'h3C, 8'hC2);
    run(11'h0C0, 7'h00, 8'h3C, 8'hC3);
    irq_en = 1'b0;
    pme_en = 1'b0;
    wb(1'b1, OFS_PWR, ZERO, q);
    run(11'h010, 7'h10, 8'h00, 8'h00);
    wb(1'b1, OFS_RECEIVE_DESCRIPTOR_POINTER, ZERO, q);
    @(posedge clk);
    #1 chk(32'(hold), 1, "null pointer keeps packet");
    wb(1'b1, OFS_RECEIVE_DESCRIPTOR_POINTER, 32'h0000_1000, q);
    @(posedge clk);
    #1 chk(32'(hold), 0, "valid pointer releases packet");
    chk(ptr, 32'h0000_1000, "pointer copy");
    wb(1'b1, OFS_WAKE_COMMAND_STATUS, 32'h0000_0001, q);
    @(posedge clk);
    ce <= 1'b0;
    phy <= 1'b1;
    @(posedge clk);
    phy <= 1'b0;
    @(posedge clk);
    ce <= 1'b1;
    wb(1'b0, OFS_WAKE_COMMAND_STATUS, ZERO, q);
    chk(q, 32'h0000_0001, "no flag while frozen");
    irq_en = 1'b1;
    pme_en = 1'b1;
    wb(1'b1, OFS_PWR, 32'h0000_0102, q);
    repeat (40) begin
      r = $random(seed);
      q = $random(seed);
      run(r[10:0], q[6:0], r[16] ? (r[17] ? 8'hA5 : 8'h3C) : r[31:24],
        r[18] ? 8'hC3 : q[15:8]);
    end
    report_and_stop();
  end
endmodule // tb_wake_on_lan_control
`default_nettype wire
